// [hw/axs_pkg.sv]
// constants, types and carriers for the accumulator sub/swap/exchange/xor slice
package axs_pkg;

  // opcode encodings; indirect forms mask bit 0, register forms mask bits 2:0
  localparam logic [7:0] OP_SBB_IMM   = 8'h94;
  localparam logic [7:0] OP_SBB_DIR   = 8'h95;
  localparam logic [7:0] OP_SBB_IND   = 8'h96;
  localparam logic [7:0] OP_SBB_REG   = 8'h98;
  localparam logic [7:0] OP_SWAP      = 8'hC4;
  localparam logic [7:0] OP_TRADE_DIR = 8'hC5;
  localparam logic [7:0] OP_TRADE_IND = 8'hC6;
  localparam logic [7:0] OP_TRADE_REG = 8'hC8;
  localparam logic [7:0] OP_NIB_IND   = 8'hD6;
  localparam logic [7:0] OP_XOR_DA    = 8'h62;
  localparam logic [7:0] OP_XOR_DI    = 8'h63;
  localparam logic [7:0] OP_XOR_IMM   = 8'h64;
  localparam logic [7:0] OP_XOR_DIR   = 8'h65;
  localparam logic [7:0] OP_XOR_IND   = 8'h66;
  localparam logic [7:0] OP_XOR_REG   = 8'h68;

  // banked register address: {REG_ADDR_TOP, bank, index}
  localparam logic [2:0] REG_ADDR_TOP = 3'h0;
  localparam logic [1:0] PTR_IDX_TOP  = 2'h0;

  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [6:0] {
    ST_IDLE      = 7'b0000001,
    ST_PTR_REQ   = 7'b0000010,
    ST_PTR_DATA  = 7'b0000100,
    ST_OPND_REQ  = 7'b0001000,
    ST_OPND_DATA = 7'b0010000,
    ST_WRITE     = 7'b0100000,
    ST_SPARE     = 7'b1000000
  } axs_state_e;

  typedef enum logic [5:0] {
    K_SBB    = 6'b000001,
    K_XORA   = 6'b000010,
    K_XORD_A = 6'b000100,
    K_XORD_I = 6'b001000,
    K_TRADE  = 6'b010000,
    K_NIB    = 6'b100000
  } axs_kind_e;

  typedef struct packed {
    logic [7:0] code;   // first instruction byte
    logic [7:0] byte2;  // second byte: direct address or immediate
    logic [7:0] byte3;  // third byte: immediate of xor direct,#data
  } axs_instr_s;

  typedef struct packed {
    logic cy;  // carry / borrow
    logic aux;  // aux_carry_flag
    logic rng;  // signed_range_flag
  } axs_flags_s;

  typedef struct packed {
    logic       rd;     // read strobe
    logic       wr;     // write strobe
    logic       latch;  // read port output latch, not pins
    logic       indir;  // indirect access: internal ram, never sfr
    logic [7:0] addr;
    logic [7:0] wdata;
  } axs_mem_s;

  localparam axs_flags_s FLAGS_RST = '{cy: 1'b0, aux: 1'b0, rng: 1'b0};
  localparam axs_mem_s   MEM_IDLE  = '{rd: 1'b0, wr: 1'b0, latch: 1'b0,
                                       indir: 1'b0, addr: 8'h00, wdata: 8'h00};

endpackage

// [hw/axs_core.sv]
// accumulator execution slice: sub_with_borrow, swap, acc_trade_byte,
// acc_trade_low_nibble and bitwise_xor_op with its operand memory port
`timescale 1ns/100ps
module axs_core (
  input  wire logic               clk,             // core clock, 40 MHz
  input  wire logic               rst_n,           // synchronous reset, low
  input  wire logic               instr_valid,     // decoded instruction offered
  input  wire axs_pkg::axs_instr_s instr,          // instruction bytes
  input  wire logic [1:0]         bank_sel,        // active register bank
  input  wire logic               acc_load,        // core writes accumulator
  input  wire logic [7:0]         acc_load_data,   // value for acc_load
  input  wire logic               flags_load,      // core writes flags
  input  wire axs_pkg::axs_flags_s flags_load_data, // value for flags_load
  input  wire logic [7:0]         mem_rd_data,     // read data, cycle after rd
  output axs_pkg::axs_mem_s       mem,             // operand memory request
  output logic [7:0]              acc,             // accumulator
  output axs_pkg::axs_flags_s     flags,           // carry, aux, overflow
  output logic                    ready,           // idle, accepts instr
  output logic                    done,            // instruction finished
  output logic                    bad_opcode       // unsupported code offered
);

  axs_pkg::axs_state_e state_r, state_nxt;
  axs_pkg::axs_kind_e  kind_r, kind_nxt;
  logic [7:0]          imm_r, imm_nxt;
  logic [7:0]          acc_r, acc_nxt;
  axs_pkg::axs_flags_s flags_r, flags_nxt;
  axs_pkg::axs_mem_s   mem_r, mem_nxt;
  logic                ready_r, ready_nxt;
  logic                done_r, done_nxt;
  logic                bad_r, bad_nxt;

  // subtract with borrow: result and the three flags
  function automatic logic [10:0] sbb_f(input logic [7:0] a, input logic [7:0] b,
                                        input logic c);
    logic [8:0] full;
    logic [7:0] low7;
    logic [4:0] low4;
    full = {1'b0, a} - {1'b0, b} - {8'h00, c};
    low7 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
    low4 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    sbb_f = {full[7:0], full[8], low4[4], low7[7] ^ full[8]};
  endfunction

  logic [7:0]  reg_addr;
  logic [7:0]  ptr_addr;
  logic [10:0] sbb_imm;
  logic [10:0] sbb_mem;
  logic [7:0]  code;

  always_comb begin
    code     = instr.code;
    reg_addr = {axs_pkg::REG_ADDR_TOP, bank_sel, code[2:0]};
    ptr_addr = {axs_pkg::REG_ADDR_TOP, bank_sel, axs_pkg::PTR_IDX_TOP,
                code[0]};
    sbb_imm  = sbb_f(acc_r, instr.byte2, flags_r.cy);
    sbb_mem  = sbb_f(acc_r, mem_rd_data, flags_r.cy);
  end

  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    imm_nxt   = imm_r;
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    mem_nxt   = mem_r;
    ready_nxt = ready_r;
    done_nxt  = 1'b0;
    bad_nxt   = 1'b0;
    mem_nxt.rd = 1'b0;
    mem_nxt.wr = 1'b0;
    unique case (state_r)
      axs_pkg::ST_IDLE: begin
        if (instr_valid) begin
          mem_nxt.latch = 1'b0;
          mem_nxt.indir = 1'b0;
          imm_nxt       = instr.byte3;
          if (code == axs_pkg::OP_SBB_IMM) begin
            acc_nxt   = sbb_imm[10:3];
            flags_nxt = '{cy: sbb_imm[2], aux: sbb_imm[1], rng: sbb_imm[0]};
            done_nxt  = 1'b1;
          end else if (code == axs_pkg::OP_SWAP) begin
            acc_nxt  = {acc_r[3:0], acc_r[7:4]};
            done_nxt = 1'b1;
          end else if (code == axs_pkg::OP_XOR_IMM) begin
            acc_nxt  = acc_r ^ instr.byte2;
            done_nxt = 1'b1;
          end else begin
            ready_nxt  = 1'b0;
            mem_nxt.rd = 1'b1;
            state_nxt  = axs_pkg::ST_OPND_REQ;
            // operand kind
            if (code[7:4] == axs_pkg::OP_SBB_IMM[7:4]) begin
              kind_nxt = axs_pkg::K_SBB;
            end else if (code[7:4] == axs_pkg::OP_XOR_IMM[7:4]) begin
              kind_nxt = axs_pkg::K_XORA;
            end else if (code[7:4] == axs_pkg::OP_NIB_IND[7:4]) begin
              kind_nxt = axs_pkg::K_NIB;
            end else begin
              kind_nxt = axs_pkg::K_TRADE;
            end
            // operand address
            if (code == axs_pkg::OP_XOR_DA || code == axs_pkg::OP_XOR_DI) begin
              kind_nxt      = (code == axs_pkg::OP_XOR_DA) ? axs_pkg::K_XORD_A
                                                           : axs_pkg::K_XORD_I;
              mem_nxt.addr  = instr.byte2;
              mem_nxt.latch = 1'b1;
            end else if (code == axs_pkg::OP_SBB_DIR || code == axs_pkg::OP_TRADE_DIR ||
                         code == axs_pkg::OP_XOR_DIR) begin
              mem_nxt.addr = instr.byte2;
            end else if (code[7:1] == axs_pkg::OP_SBB_IND[7:1]   ||
                         code[7:1] == axs_pkg::OP_TRADE_IND[7:1] ||
                         code[7:1] == axs_pkg::OP_NIB_IND[7:1]   ||
                         code[7:1] == axs_pkg::OP_XOR_IND[7:1]) begin
              mem_nxt.addr = ptr_addr;
              state_nxt    = axs_pkg::ST_PTR_REQ;
            end else if (code[7:3] == axs_pkg::OP_SBB_REG[7:3]   ||
                         code[7:3] == axs_pkg::OP_TRADE_REG[7:3] ||
                         code[7:3] == axs_pkg::OP_XOR_REG[7:3]) begin
              mem_nxt.addr = reg_addr;
            end else begin
              ready_nxt  = 1'b1;
              mem_nxt.rd = 1'b0;
              state_nxt  = axs_pkg::ST_IDLE;
              bad_nxt    = 1'b1;
            end
          end
        end else begin
          if (acc_load) begin
            acc_nxt = acc_load_data;
          end
          if (flags_load) begin
            flags_nxt = flags_load_data;
          end
        end
      end
      axs_pkg::ST_PTR_REQ: begin
        state_nxt = axs_pkg::ST_PTR_DATA;
      end
      axs_pkg::ST_PTR_DATA: begin
        // pointer value now present: fetch the byte it points at
        mem_nxt.rd    = 1'b1;
        mem_nxt.indir = 1'b1;
        mem_nxt.addr  = mem_rd_data;
        state_nxt     = axs_pkg::ST_OPND_REQ;
      end
      axs_pkg::ST_OPND_REQ: begin
        state_nxt = axs_pkg::ST_OPND_DATA;
      end
      axs_pkg::ST_OPND_DATA: begin
        state_nxt = axs_pkg::ST_WRITE;
        mem_nxt.wr = 1'b1;
        unique case (kind_r)
          axs_pkg::K_SBB: begin
            acc_nxt    = sbb_mem[10:3];
            flags_nxt  = '{cy: sbb_mem[2], aux: sbb_mem[1], rng: sbb_mem[0]};
            mem_nxt.wr = 1'b0;
            state_nxt  = axs_pkg::ST_IDLE;
          end
          axs_pkg::K_XORA: begin
            acc_nxt    = acc_r ^ mem_rd_data;
            mem_nxt.wr = 1'b0;
            state_nxt  = axs_pkg::ST_IDLE;
          end
          axs_pkg::K_XORD_A: begin
            mem_nxt.wdata = mem_rd_data ^ acc_r;
          end
          axs_pkg::K_XORD_I: begin
            mem_nxt.wdata = mem_rd_data ^ imm_r;
          end
          axs_pkg::K_TRADE: begin
            acc_nxt       = mem_rd_data;
            mem_nxt.wdata = acc_r;
          end
          axs_pkg::K_NIB: begin
            acc_nxt       = {acc_r[7:4], mem_rd_data[3:0]};
            mem_nxt.wdata = {mem_rd_data[7:4], acc_r[3:0]};
          end
          default: begin
            mem_nxt.wr = 1'b0;
            state_nxt  = axs_pkg::ST_IDLE;
          end
        endcase
        if (state_nxt == axs_pkg::ST_IDLE) begin
          ready_nxt = 1'b1;
          done_nxt  = 1'b1;
        end
      end
      axs_pkg::ST_WRITE: begin
        state_nxt = axs_pkg::ST_IDLE;
        ready_nxt = 1'b1;
        done_nxt  = 1'b1;
      end
      default: begin
        state_nxt = axs_pkg::ST_IDLE;
        ready_nxt = 1'b1;
        mem_nxt   = axs_pkg::MEM_IDLE;
      end
    endcase
  end

  // sequencing state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= axs_pkg::ST_IDLE;
      kind_r  <= axs_pkg::K_SBB;
      imm_r   <= axs_pkg::BYTE_RST;
      ready_r <= 1'b1;
      done_r  <= 1'b0;
      bad_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      imm_r   <= imm_nxt;
      ready_r <= ready_nxt;
      done_r  <= done_nxt;
      bad_r   <= bad_nxt;
    end
  end

  // accumulator and flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r   <= axs_pkg::ACC_RST;
      flags_r <= axs_pkg::FLAGS_RST;
    end else begin
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
    end
  end

  // operand memory port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_r <= axs_pkg::MEM_IDLE;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign mem        = mem_r;
  assign acc        = acc_r;
  assign flags      = flags_r;
  assign ready      = ready_r;
  assign done       = done_r;
  assign bad_opcode = bad_r;

endmodule

// [bench/axs_core_sva.sv]
// port assertions for the accumulator slice
`timescale 1ns/100ps
module axs_core_sva (
  input wire logic                clk,         // core clock
  input wire logic                rst_n,       // sync reset, low
  input wire logic                instr_valid, // instruction offered
  input wire axs_pkg::axs_instr_s instr,       // instruction bytes
  input wire logic [1:0]          bank_sel,    // active bank
  input wire axs_pkg::axs_mem_s   mem,         // operand request
  input wire logic [7:0]          acc,         // accumulator
  input wire axs_pkg::axs_flags_s flags,       // carry, aux, range
  input wire logic                ready,       // idle
  input wire logic                done         // finished
);
  logic       tk;
  logic [7:0] op;
  assign tk = ready && instr_valid;
  assign op = instr.code;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_swap_nibbles: assert property (tk && op == 8'hC4 |=> done
    && acc == {$past(acc[3:0]), $past(acc[7:4])}) else $error("swap result wrong");
  a_swap_flags: assert property (tk && op == 8'hC4 |=> flags == $past(flags))
    else $error("swap touched flags");
  a_imm_result: assert property (tk && op == 8'h94 |=> done
    && acc == 8'($past(acc) - $past(instr.byte2) - $past(flags.cy))) else $error("sub_with_borrow imm wrong");
  a_imm_borrow: assert property (tk && op == 8'h94 |=> flags.cy ==
    ({1'b0, $past(acc)} < {1'b0, $past(instr.byte2)} + $past(flags.cy))) else $error("carry wrong");
  a_imm_aux: assert property (tk && op == 8'h94 |=> flags.aux ==
    ({1'b0, $past(acc[3:0])} < {1'b0, $past(instr.byte2[3:0])} + $past(flags.cy)))
    else $error("aux carry wrong");
  a_xor_imm: assert property (tk && op == 8'h64 |=> done && flags == $past(flags)
    && acc == ($past(acc) ^ $past(instr.byte2))) else $error("xor imm wrong");
  a_latch_read: assert property (tk && op == 8'h63 |=> mem.rd && mem.latch
    && mem.addr == $past(instr.byte2)) else $error("port read not from latch");
  a_ptr_fetch: assert property (tk && op == 8'h97 |=> mem.rd && !mem.indir
    && mem.addr == {3'h0, $past(bank_sel), 3'h1}) else $error("pointer address wrong");
endmodule
bind axs_core axs_core_sva chk_u (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr(instr), .bank_sel(bank_sel), .mem(mem), .acc(acc), .flags(flags),
  .ready(ready), .done(done));

// [bench/test_axs_core.sv]
// self-checking bench for the accumulator slice
`timescale 1ns/100ps
module test_axs_core;
  logic                clk, rst_n, iv, al, fl, rdy, done, bad, hold;
  axs_pkg::axs_instr_s ins;
  axs_pkg::axs_flags_s fld, flg;
  axs_pkg::axs_mem_s   mem;
  logic [1:0]          bk;
  logic [7:0]          ald, rdd, acc;
  logic [7:0]          ram [256];
  int                  n_mismatch, cmp_count;
  axs_core dut_u (.clk(clk), .rst_n(rst_n), .instr_valid(iv), .instr(ins), .bank_sel(bk),
    .acc_load(al), .acc_load_data(ald), .flags_load(fl), .flags_load_data(fld),
    .mem_rd_data(rdd), .mem(mem), .acc(acc), .flags(flg), .ready(rdy), .done(done),
    .bad_opcode(bad));
  always #12.5 clk = ~clk;
  // read data stands one cycle after rd, then turns over so stale data is seen
  always @(negedge clk) begin
    if (mem.rd)
      rdd <= ram[mem.addr];
    else if (!hold)
      rdd <= ~rdd;
    hold <= mem.rd;
  end
  always @(posedge clk) begin
    if (mem.wr)
      ram[mem.addr] <= mem.wdata;
  end
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic pre(logic [7:0] a, logic [2:0] f);
    ald = a;
    fld = f;
    al = 1;
    fl = 1;
    @(negedge clk);
    al = 0;
    fl = 0;
  endtask
  task automatic run(logic [7:0] c, logic [7:0] b2, logic [7:0] b3);
    int n;
    ins = {c, b2, b3};
    iv = 1;
    n = 1;
    @(negedge clk);
    iv = 0;
    while (done !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    if (n > 8) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic t_sub_with_borrow();
    logic [7:0] a [4] = '{8'hC9, 8'h00, 8'h80, 8'h7F};
    logic [7:0] b [4] = '{8'h54, 8'h01, 8'h01, 8'hFF};
    logic [7:0] o [4] = '{8'h9A, 8'h94, 8'h97, 8'h95};
    logic [8:0] d;
    logic [4:0] h;
    logic       c;
    for (int k = 0; k < 4; k++) begin
      c = ~k[0];
      ram[8'h12] = b[k];
      ram[8'h11] = 8'h40;
      ram[8'h40] = b[k];
      ram[8'h33] = b[k];
      pre(a[k], {c, 2'b00});
      run(o[k], k == 1 ? b[k] : 8'h33, 8'h00);
      d = {1'b0, a[k]} - {1'b0, b[k]} - c;
      h = {1'b0, a[k][3:0]} - {1'b0, b[k][3:0]} - c;
      chk(acc, d[7:0]);
      chk(8'(flg), 8'({d[8], h[4], (a[k][7] ^ b[k][7]) & (d[7] ^ a[k][7])}));
    end
  endtask
  task automatic t_swap();
    pre(8'hC5, 3'h5);
    run(8'hC4, 8'h00, 8'h00);
    chk(acc, 8'h5C);
    chk(8'(flg), 8'h05);
  endtask
  task automatic t_xch();
    logic [7:0] o [3] = '{8'hC9, 8'hC5, 8'hC7};
    for (int k = 0; k < 3; k++) begin
      ram[8'h11] = 8'h20;
      ram[8'h20] = 8'h75;
      pre(8'h3F, 3'h0);
      run(o[k], 8'h20, 8'h00);
      chk(acc, k == 0 ? 8'h20 : 8'h75);
      chk(ram[k == 0 ? 8'h11 : 8'h20], 8'h3F);
    end
  endtask
  task automatic t_acc_trade_low_nibble();
    ram[8'h10] = 8'h20;
    ram[8'h20] = 8'h75;
    pre(8'h36, 3'h7);
    run(8'hD6, 8'h00, 8'h00);
    chk(acc, 8'h35);
    chk(ram[8'h20], 8'h76);
    chk(8'(flg), 8'h07);
  endtask
  task automatic t_xrl();
    logic [7:0] o [6] = '{8'h68, 8'h65, 8'h67, 8'h64, 8'h62, 8'h63};
    for (int k = 0; k < 6; k++) begin
      ram[8'h10] = 8'hAA;
      ram[8'h11] = 8'h30;
      ram[8'h30] = 8'hAA;
      pre(8'hC3, 3'h5);
      run(o[k], k == 3 ? 8'hAA : 8'h30, 8'h31);
      chk(acc, k < 4 ? 8'h69 : 8'hC3);
      chk(ram[8'h30], k == 4 ? 8'h69 : k == 5 ? 8'h9B : 8'hAA);
      chk(8'(flg), 8'h05);
    end
  endtask
  task automatic t_bad();
    pre(8'h5A, 3'h2);
    ins = {8'h60, 8'h00, 8'h00};
    iv = 1;
    @(negedge clk);
    iv = 0;
    chk(8'(bad), 8'h01);
    chk(8'(done), 8'h00);
    chk(8'(rdy), 8'h01);
    chk(acc, 8'h5A);
    chk(8'(flg), 8'h02);
    @(negedge clk);
    chk(8'(bad), 8'h00);
  endtask
  initial begin
    clk = 0;
    rst_n = 0;
    {iv, al, fl, hold} = '0;
    {ins, fld, ald, rdd} = '0;
    bk = 2'h2;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_sub_with_borrow();
    t_swap();
    t_xch();
    t_acc_trade_low_nibble();
    t_xrl();
    t_bad();
    wrap_up();
  end
endmodule
